// ==== core/cgs_consts.vh ====
// How it works
// - Strap pins are inputs at power-up
// - After 2 ms straps become clock outputs
// - One short CPU cycle allowed at enable
// - CPU clock inverted to SDRAM at 100 MHz
// - Low power: PLLs stop, outputs LOW
// - Two low CPU rises, freeze at fall
// - Power-down input synchronised before use
// - Spread spectrum deviates plus/minus half percent
// - Only block writes accepted
// - Ascending bytes, completed bytes kept
// - Respond only to address byte 11010010
// - Command and count bytes are ignored
// - Valid after count acknowledge; data updates
// - Device acknowledges each byte of a frame sent to its address
// - Outputs other than CPU, 66 MHz and REF disableable, disabled held LOW
// - Data byte k loads byte k, whatever the count
// - Bytes six and seven ignored
// - Bits assembled MSB first
`ifndef CGS_CONSTS_VH
`define CGS_CONSTS_VH

`define CGS_MCLK_MHZ       100
`define CGS_STRAP_TIME_US  2000
`define CGS_STRAP_CYCLES   (`CGS_STRAP_TIME_US * `CGS_MCLK_MHZ)
`define CGS_SS_DIV         200
`define CGS_PD_EDGES       2'h2
`define CGS_SLAVE_ADDR     8'hD2
`define CGS_NUM_BYTES      3'h6
`define CGS_ACK_PHASE      4'h9
`define CGS_LAST_BIT       4'h8
`define CGS_CPU100_A       5'h0D
`define CGS_CPU100_B       5'h1D
`define CGS_RST_BYTE0      8'h06
`define CGS_RST_BYTE1      8'hFF
`define CGS_RST_BYTE2      8'hFF
`define CGS_RST_BYTE3      8'h8A
`define CGS_RST_BYTE4      8'h02
`define CGS_RST_BYTE5      8'h00
`define CGS_B0_SIO         2
`define CGS_B0_USB         1
`define CGS_B3_DCLK        7
`define CGS_B3_APIC        3
`define CGS_B4_OVR         3

`endif

// ==== core/cgs_top.v ====
`timescale 1ns/10ps
`default_nettype none
`include "cgs_consts.vh"

module cgs_top #(
  parameter [31:0] STRAP_CYCLES = `CGS_STRAP_CYCLES,
  parameter [31:0] CPU_INC      = 32'h4000_0000,
  parameter [31:0] USB_INC      = 32'h1EB8_51EC,
  parameter [31:0] REF_INC      = 32'h0924_DD2F,
  parameter [31:0] SS_STEP      = 32'h0000_1A00,
  parameter [31:0] SS_CODE_MASK = 32'hFFFF_FFFF
) (
  input  wire        mclk,                // Core clock, 100 MHz
  input  wire        arst_n,              // Power-up reset, async
  input  wire        low_power_request_n, // Async power-down request
  input  wire        smb_scl,             // SMBus clock pin
  input  wire        smb_sda_in,          // SMBus data pin level
  output wire        smb_sda_out,         // SMBus data drive value
  output reg         smb_sda_oe_n,        // Low while pulling data low
  input  wire [5:0]  strap_in,            // Dual pins, strap level
  output reg  [5:0]  strap_out,           // Dual pins, clock value
  output reg  [5:0]  strap_oe_n,          // Low while pins drive
  output reg  [1:0]  cpu_clk,             // CPU clocks
  output reg  [8:0]  sdram_clk,           // SDRAM 0..7 and DCLK
  output reg  [7:3]  pci_clk,             // PCI clocks 3..7
  output reg  [1:0]  v66_clk,             // 66 MHz group
  output reg         apic_clk,            // APIC clock
  output reg         usb_clk              // Fixed 48 MHz output
);

  // One-hot receiver states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_CMD  = 5'h04;
  localparam [4:0] S_CNT  = 5'h08;
  localparam [4:0] S_DATA = 5'h10;
  // Half a percent of the nominal CPU phase step
  localparam [31:0] SS_DEV = CPU_INC / `CGS_SS_DIV;

  // Power-up strap window
  reg [31:0] por_cnt_q;
  reg        strap_done_q;
  reg [5:0]  strap_s1_q;
  reg [5:0]  strap_s2_q;
  reg [4:0]  freq_select_straps;
  reg        sio_24_q;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_q    <= 32'h0000_0000;
      strap_done_q <= 1'b0;
      strap_s1_q   <= 6'h00;
      strap_s2_q   <= 6'h00;
      freq_select_straps <= 5'h00;
      sio_24_q     <= 1'b0;
    end else begin
      strap_s1_q <= strap_in;
      strap_s2_q <= strap_s1_q;
      // Counter parks once the window closes, so it never wraps
      if (!strap_done_q) begin
        por_cnt_q <= por_cnt_q + 32'h0000_0001;
        if (por_cnt_q >= STRAP_CYCLES - 32'h0000_0001) begin
          strap_done_q       <= 1'b1;
          freq_select_straps <= strap_s2_q[4:0];
          sio_24_q           <= strap_s2_q[5];
        end
      end
    end
  end

  // Configuration bytes written over SMBus
  reg [7:0] cfg_q [0:5];
  wire [4:0] sel_code;
  wire       cpu100;
  wire       ss_on;

  // The override bit lets software pick a mode in place of the strapped one
  assign sel_code = cfg_q[4][`CGS_B4_OVR] ?
                    {cfg_q[4][2], cfg_q[4][7:4]} : freq_select_straps;
  assign cpu100   = (sel_code == `CGS_CPU100_A) ||
                    (sel_code == `CGS_CPU100_B);
  assign ss_on    = SS_CODE_MASK[sel_code];

  // Power-down synchroniser and freeze
  reg        pd_s1_q;
  reg        pd_s2_q;
  reg [1:0]  pd_low_q;
  reg        pd_q;
  reg        cpu_prev_q;
  reg [31:0] cpu_acc_q;
  reg [31:0] usb_acc_q;
  reg [31:0] ref_acc_q;
  reg [31:0] tri_q;
  reg        tri_up_q;
  reg [2:0]  div_q;
  reg        sio_div_q;
  reg        usb_prev_q;

  wire cpu_raw;
  wire cpu_rise;
  wire cpu_fall;
  wire usb_raw;
  wire out_en;

  // Edges compare the phase bit with its value one cycle back
  assign cpu_raw  = cpu_acc_q[31];
  assign cpu_rise = cpu_raw & ~cpu_prev_q;
  assign cpu_fall = ~cpu_raw & cpu_prev_q;
  assign usb_raw  = usb_acc_q[31];
  // Outputs stay quiet through the strap window and in low power
  assign out_en   = strap_done_q & ~pd_q;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pd_s1_q  <= 1'b1;
      pd_s2_q  <= 1'b1;
      pd_low_q <= 2'h0;
      pd_q     <= 1'b0;
    end else begin
      pd_s1_q <= low_power_request_n;
      pd_s2_q <= pd_s1_q;
      if (pd_s2_q) begin
        pd_low_q <= 2'h0;
        pd_q     <= 1'b0;
      end else begin
        // A single low sample never stops the clocks
        if (cpu_rise && pd_low_q != `CGS_PD_EDGES) begin
          pd_low_q <= pd_low_q + 2'h1;
        end
        if (pd_low_q == `CGS_PD_EDGES && cpu_fall) begin
          pd_q <= 1'b1;
        end
      end
    end
  end

  // Digital stand-ins for the PLLs; they hold still in low power
  wire [31:0] cpu_inc;

  assign cpu_inc = ss_on ? CPU_INC + tri_q : CPU_INC;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_acc_q  <= 32'h0000_0000;
      usb_acc_q  <= 32'h0000_0000;
      ref_acc_q  <= 32'h0000_0000;
      tri_q      <= 32'h0000_0000;
      tri_up_q   <= 1'b1;
      cpu_prev_q <= 1'b0;
      usb_prev_q <= 1'b0;
      div_q      <= 3'h0;
      sio_div_q  <= 1'b0;
    end else if (!pd_q) begin
      cpu_acc_q  <= cpu_acc_q + cpu_inc;
      usb_acc_q  <= usb_acc_q + USB_INC;
      ref_acc_q  <= ref_acc_q + REF_INC;
      cpu_prev_q <= cpu_raw;
      usb_prev_q <= usb_raw;
      // Triangle profile spanning plus/minus SS_DEV
      if (tri_up_q) begin
        if ($signed(tri_q) >= $signed(SS_DEV)) begin
          tri_up_q <= 1'b0;
        end else begin
          tri_q <= tri_q + SS_STEP;
        end
      end else begin
        if ($signed(tri_q) <= -$signed(SS_DEV)) begin
          tri_up_q <= 1'b1;
        end else begin
          tri_q <= tri_q - SS_STEP;
        end
      end

      // div_q counts CPU rises so the slow groups stay aligned to it; the SIO divider counts USB rises
      if (cpu_rise) begin
        div_q <= div_q + 3'h1;
      end
      if (usb_raw & ~usb_prev_q) begin
        sio_div_q <= ~sio_div_q;
      end
    end
  end

  // Output stage: gated and registered. The first enabled CPU period
  // may be cut short since the gate opens at any accumulator phase.
  wire pci_raw;
  wire sio_raw;
  wire sd_raw;
  wire usb_en;

  assign pci_raw = div_q[1];
  assign sio_raw = sio_24_q ? sio_div_q : usb_raw;
  assign sd_raw  = cpu_raw ^ cpu100;
  assign usb_en  = cfg_q[0][`CGS_B0_USB];

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk    <= 2'h0;
      sdram_clk  <= 9'h000;
      pci_clk    <= 5'h00;
      v66_clk    <= 2'h0;
      apic_clk   <= 1'b0;
      usb_clk    <= 1'b0;
      strap_out  <= 6'h00;
      strap_oe_n <= 6'h3F;
    end else begin
      strap_oe_n <= {6{~strap_done_q}};
      cpu_clk    <= {2{out_en & cpu_raw}};
      v66_clk    <= {2{out_en & div_q[0]}};
      // Disabled outputs are held LOW, never tri-stated
      sdram_clk[7:0] <= {8{out_en & sd_raw}} & cfg_q[1];
      sdram_clk[8]   <= out_en & sd_raw &
                        cfg_q[3][`CGS_B3_DCLK];
      pci_clk    <= {5{out_en & pci_raw}} & cfg_q[2][7:3];
      apic_clk   <= out_en & div_q[2] & cfg_q[3][`CGS_B3_APIC];
      usb_clk    <= out_en & usb_raw & usb_en;
      strap_out[2:0] <= {3{out_en & pci_raw}} & cfg_q[2][2:0];
      strap_out[3]   <= out_en & ref_acc_q[31];
      strap_out[4]   <= out_en & usb_raw & usb_en;
      strap_out[5]   <= out_en & sio_raw &
                        cfg_q[0][`CGS_B0_SIO];
    end
  end

  // SMBus slave receiver, block write only
  // Third stage only finds edges; all other logic reads the second
  reg       scl_s1_q;
  reg       scl_s2_q;
  reg       scl_s3_q;
  reg       sda_s1_q;
  reg       sda_s2_q;
  reg       sda_s3_q;

  reg [4:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [2:0] idx_q;
  reg       ack_q;

  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  // Data moving while the link clock is high marks START or STOP
  assign start_c  = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign stop_c   = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  // Open drain: only the enable ever moves, never the value
  assign smb_sda_out = 1'b0;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      smb_sda_oe_n <= 1'b1;
    end else begin
      // Registered so the data pin never glitches low
      smb_sda_oe_n <= ~ack_q;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      st_q     <= S_IDLE;
      bit_q    <= 4'h0;
      shift_q  <= 8'h00;
      idx_q    <= 3'h0;
      ack_q    <= 1'b0;
      cfg_q[0] <= `CGS_RST_BYTE0;
      cfg_q[1] <= `CGS_RST_BYTE1;
      cfg_q[2] <= `CGS_RST_BYTE2;
      cfg_q[3] <= `CGS_RST_BYTE3;
      cfg_q[4] <= `CGS_RST_BYTE4;
      cfg_q[5] <= `CGS_RST_BYTE5;
    end else begin
      scl_s1_q <= smb_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= smb_sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      if (start_c) begin
        st_q  <= S_ADDR;
        bit_q <= 4'h0;
        ack_q <= 1'b0;
      end else if (stop_c) begin
        // A STOP between bytes keeps whatever was already stored
        st_q  <= S_IDLE;
        ack_q <= 1'b0;
      end else if (st_q != S_IDLE) begin
        if (scl_rise && bit_q < `CGS_LAST_BIT) begin
          shift_q <= {shift_q[6:0], sda_s2_q};
          bit_q   <= bit_q + 4'h1;
        end else if (scl_fall && bit_q == `CGS_ACK_PHASE) begin
          ack_q <= 1'b0;
          bit_q <= 4'h0;
        end else if (scl_fall && bit_q == `CGS_LAST_BIT) begin
          bit_q <= `CGS_ACK_PHASE;
          case (st_q)
            S_ADDR: begin
              if (shift_q == `CGS_SLAVE_ADDR) begin
                ack_q <= 1'b1;
                st_q  <= S_CMD;
              end else begin
                // Foreign frames are ignored until the next START
                st_q <= S_IDLE;
              end
            end
            S_CMD: begin
              ack_q <= 1'b1;
              st_q  <= S_CNT;
            end
            S_CNT: begin
              ack_q <= 1'b1;
              idx_q <= 3'h0;
              st_q  <= S_DATA;
            end
            S_DATA: begin
              ack_q <= 1'b1;
              if (idx_q < `CGS_NUM_BYTES) begin
                cfg_q[idx_q] <= shift_q;
              end
              // Index saturates so late bytes never wrap onto byte 0
              if (idx_q != 3'h7) begin
                idx_q <= idx_q + 3'h1;
              end
            end
            default: begin
              st_q <= S_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/cgs_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module cgs_chk #(
  parameter [31:0] STRAP_CYCLES = 32'h0000_0032
) (
  input wire logic       mclk,                // Core clock
  input wire logic       arst_n,              // Async reset
  input wire logic       low_power_request_n, // Power-down request
  input wire logic       smb_scl,             // Link clock
  input wire logic       smb_sda_out,         // Data drive value
  input wire logic       smb_sda_oe_n,        // Data drive enable
  input wire logic [5:0] strap_in,            // Strap pin level
  input wire logic [5:0] strap_oe_n,          // Strap drive enable
  input wire logic [1:0] cpu_clk,             // CPU clocks
  input wire logic [8:0] sdram_clk,           // SDRAM clocks
  input wire logic       usb_clk              // 48 MHz clock
);
  logic [31:0] up_q;
  logic [4:0]  lo_q;
  logic [4:0]  md_q;
  // Mode is latched at the same edge the design samples its straps
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      up_q <= 32'h0000_0000;
      lo_q <= 5'h00;
      md_q <= 5'h00;
    end else begin
      if (up_q < STRAP_CYCLES + 8) up_q <= up_q + 32'h0000_0001;
      if (up_q == STRAP_CYCLES - 1) md_q <= strap_in[4:0];
      if (low_power_request_n) lo_q <= 5'h00;
      else if (lo_q != 5'h1F) lo_q <= lo_q + 5'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  strap_hold_a: assert property (
    up_q < STRAP_CYCLES |-> strap_oe_n == 6'h3F && cpu_clk == 2'h0)
    else $error("strap pins driven early");
  strap_drive_a: assert property (
    up_q > STRAP_CYCLES + 1 |-> strap_oe_n == 6'h00)
    else $error("strap pins not driven");
  pd_low_a: assert property (
    lo_q > 5'h18 |-> cpu_clk == 2'h0 && sdram_clk == 9'h000 && !usb_clk)
    else $error("clock running in power down");
  pd_wait_a: assert property (
    up_q == STRAP_CYCLES + 8 && $fell(low_power_request_n)
    |-> ##[1:8] $rose(cpu_clk[0]))
    else $error("power down entered too soon");
  cpu_sdram_a: assert property (
    md_q inside {5'h0D, 5'h1D} && sdram_clk[0] |-> !cpu_clk[0])
    else $error("cpu and sdram clocks in phase");
  ack_stand_a: assert property (
    $fell(smb_sda_oe_n) |-> !smb_sda_oe_n [*8])
    else $error("acknowledge too short");
  ack_edge_a: assert property (
    $changed(smb_sda_oe_n) |-> !smb_scl)
    else $error("data drive changed while link clock high");
  sda_drive_a: assert property (
    smb_sda_out == 1'b0)
    else $error("data line driven high");
endmodule
`default_nettype wire

// ==== test/cgs_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module cgs_host (
  output logic      scl,     // Link clock, high between frames
  output logic      sda_drv, // Data drive, 1 releases the line
  input  wire logic sda      // Resolved data line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      #31.25 scl = 1'b1;
      #62.5 scl = 1'b0;
      #31.25;
    end
    sda_drv = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 ack = !sda;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // Block write only; a missing address answer ends the frame at once
  task automatic frame(input logic [7:0] adr, cnt, input int n,
                       input logic [63:0] d, output int acks);
    logic a;
    acks = 0;
    sda_drv = 1'b0;
    #31.25 scl = 1'b0;
    #31.25;
    put(adr, a);
    if (a) begin
      acks = 1;
      put(8'h00, a);
      acks += int'(a);
      put(cnt, a);
      acks += int'(a);
      for (int k = 0; k < n; k++) begin
        put(d[8*k +: 8], a);
        acks += int'(a);
      end
    end
    sda_drv = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_drv = 1'b1;
    #62.5;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [31:0] STRAP_CYCLES = 32'h0000_0032;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic       low_power_request_n = 1'b1;
  logic       sda_drv;
  logic       smb_scl;
  logic       smb_sda_out;
  logic       smb_sda_oe_n;
  logic [5:0] strap_out;
  logic [5:0] strap_oe_n;
  logic [1:0] cpu_clk;
  logic [8:0] sdram_clk;
  logic [7:3] pci_clk;
  logic [1:0] v66_clk;
  logic       apic_clk;
  logic       usb_clk;
  int         bad_count = 0;
  int         checked = 0;
  int         cyc = 0;
  // Pull-up on data; strap pins show the resistor until the device drives
  wire        sda_line = sda_drv & (smb_sda_oe_n | smb_sda_out);
  wire [5:0]  strap_pin = (strap_oe_n & 6'h0D) | (~strap_oe_n & strap_out);
  cgs_top #(.STRAP_CYCLES(STRAP_CYCLES)) uut (
    .mclk(mclk), .arst_n(arst_n), .low_power_request_n(low_power_request_n),
    .smb_scl(smb_scl), .smb_sda_in(sda_line), .smb_sda_out(smb_sda_out),
    .smb_sda_oe_n(smb_sda_oe_n), .strap_in(strap_pin), .strap_out(strap_out),
    .strap_oe_n(strap_oe_n), .cpu_clk(cpu_clk), .sdram_clk(sdram_clk),
    .pci_clk(pci_clk), .v66_clk(v66_clk), .apic_clk(apic_clk),
    .usb_clk(usb_clk));
  cgs_host host (.scl(smb_scl), .sda_drv(sda_drv), .sda(sda_line));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  task automatic check(input string nm, input logic [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [23:0] ex(input logic [7:0] b0, b1, b2, b3);
    return {b0[1], b3[3], b2[7:3], b3[7], b1, 2'h3, b0[2], b0[1], 1'b1,
            b2[2:0]};
  endfunction
  // A disabled clock never shows a high level over the window
  task automatic cfg(input string nm, input logic [23:0] e);
    logic [23:0] v;
    logic [1:0]  w;
    v = 24'h00_0000;
    w = 2'h0;
    repeat (64) begin
      @(negedge mclk);
      v |= {usb_clk, apic_clk, pci_clk, sdram_clk, cpu_clk, strap_out};
      w |= v66_clk;
    end
    check(nm, v, e);
    check({nm, " 66"}, 24'(w), (e != 24'h0) ? 24'h00_0003 : 24'h00_0000);
  endtask
  task automatic wr(input logic [7:0] adr, cnt, input int n,
                    input logic [63:0] d, input int na);
    int acks;
    host.frame(adr, cnt, n, d, acks);
    check("acknowledges", 24'(acks), 24'(na));
  endtask
  task automatic t_power_up;
    int inv;
    inv = 0;
    repeat (10) @(negedge mclk);
    check("strap early", 24'(strap_oe_n), 24'h00_003F);
    repeat (50) @(negedge mclk);
    check("strap late", 24'(strap_oe_n), 24'h00_0000);
    cfg("reset outputs", ex(8'h06, 8'hFF, 8'hFF, 8'h8A));
    repeat (16) begin
      @(negedge mclk);
      inv += int'(sdram_clk[0] !== ~cpu_clk[0]);
    end
    check("cpu vs sdram", 24'(inv), 24'h00_0000);
    $display("power-up test done");
  endtask
  task automatic t_write;
    wr(8'hD2, 8'h03, 3, 64'h0000_0000_00A5_0F02, 6);
    cfg("three bytes", ex(8'h02, 8'h0F, 8'hA5, 8'h8A));
    $display("write test done");
  endtask
  task automatic t_abort;
    wr(8'hD2, 8'h04, 2, 64'h0000_0000_0000_F006, 5);
    cfg("stopped early", ex(8'h06, 8'hF0, 8'hA5, 8'h8A));
    $display("abort test done");
  endtask
  task automatic t_extra;
    wr(8'hD2, 8'h08, 8, 64'hFFFF_0000_88FF_FF06, 11);
    cfg("bytes six seven", ex(8'h06, 8'hFF, 8'hFF, 8'h88));
    $display("extra bytes test done");
  endtask
  task automatic t_bad_addr;
    wr(8'hD3, 8'h01, 1, 64'h0000_0000_0000_0000, 0);
    wr(8'hD0, 8'h01, 1, 64'h0000_0000_0000_0000, 0);
    cfg("foreign address", ex(8'h06, 8'hFF, 8'hFF, 8'h88));
    $display("address test done");
  endtask
  task automatic t_power_down;
    @(posedge mclk);
    low_power_request_n <= 1'b0;
    repeat (30) @(posedge mclk);
    cfg("power down", 24'h00_0000);
    @(posedge mclk);
    low_power_request_n <= 1'b1;
    repeat (30) @(posedge mclk);
    cfg("resumed", ex(8'h06, 8'hFF, 8'hFF, 8'h88));
    $display("power-down test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    t_power_up;
    t_write;
    t_abort;
    t_extra;
    t_bad_addr;
    t_power_down;
    finish_test;
  end
endmodule
bind cgs_top cgs_chk #(.STRAP_CYCLES(STRAP_CYCLES)) chk (
  .mclk(mclk), .arst_n(arst_n), .low_power_request_n(low_power_request_n),
  .smb_scl(smb_scl), .smb_sda_out(smb_sda_out), .smb_sda_oe_n(smb_sda_oe_n),
  .strap_in(strap_in), .strap_oe_n(strap_oe_n), .cpu_clk(cpu_clk),
  .sdram_clk(sdram_clk), .usb_clk(usb_clk));
`default_nettype wire
